// *** shared/csfr_pkg.sv ***
// Functional notes
// - status register is a normal destination for any data-memory write.
// - flag writes to zero, digit-carry, carry lose to ALU-updated flag values.
// - watchdog expiry and sleep entry flags ignore every register write.
// - clearing status gives 000u u1uu: top three zero, zero flag set.
// - in subtraction carry and digit-carry hold inverted borrow; one means none.
// - upper pc byte not addressable; five-bit hold register feeds it.
// - unimplemented locations, 19Fh included, read zero and ignore writes.
// - one byte holds ALU flags, reset-cause flags and bank select bits.
// - status mirrored at 03h, 83h, 103h and 183h.
// - indirect bank bit one selects 100h-1FFh, zero selects 00h-FFh.
package csfr_pkg;

    // ------------------------------------------------------------
    // data-memory map (word index; byte address is index times four)
    // ------------------------------------------------------------
    localparam int unsigned DATA_AW     = 9;
    localparam int unsigned APB_AW      = 11;
    localparam logic [6:0]  STATUS_LOW  = 7'h03; // same in every bank
    localparam logic [8:0]  STATUS_B0   = 9'h003;
    localparam logic [8:0]  STATUS_B1   = 9'h083;
    localparam logic [8:0]  STATUS_B2   = 9'h103;
    localparam logic [8:0]  STATUS_B3   = 9'h183;
    localparam logic [6:0]  PCHOLD_LOW  = 7'h0a; // same in every bank
    localparam logic [8:0]  UNIMPL_LAST = 9'h19f;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_C     = 0;
    localparam int unsigned BIT_NIB   = 1;
    localparam int unsigned BIT_Z     = 2;
    localparam int unsigned BIT_SLEEP = 3;
    localparam int unsigned BIT_WDOG  = 4;
    localparam int unsigned BIT_RP0   = 5;
    localparam int unsigned BIT_RP1   = 6;
    localparam int unsigned BIT_IBANK = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h18; // both reset-cause flags 1
    localparam int unsigned PCHOLD_W  = 5;
    localparam logic [4:0] PCHOLD_RST = 5'h00;
    localparam logic [4:0] PCUPPER_RST = 5'h00;

endpackage

// *** verilog/csfr_bank_addr.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------------
// bank address former for direct and indirect access
// --------------------------------------------------------------------
module csfr_bank_addr (
    input  wire logic [1:0] bankSel,
    input  wire logic       indirectBankBit,
    input  wire logic [6:0] directOffset,
    input  wire logic [7:0] pointerValue,
    output logic      [8:0] directAddr,
    output logic      [8:0] indirectAddr
);

    // direct: two bank bits pick one 128-byte bank
    assign directAddr   = {bankSel, directOffset};
    // indirect: one bit picks banks 0-1 or banks 2-3
    assign indirectAddr = {indirectBankBit, pointerValue};

endmodule

// *** verilog/csfr_status_reg.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------------
// cpu status register, pc upper hold and data-space decode
// --------------------------------------------------------------------
module csfr_status_reg (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // apb slave: data-memory window of the core
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [csfr_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // alu flag results, same cycle as the instruction completes
    input  wire logic                        aluZeroUpd,
    input  wire logic                        aluDigitUpd,
    input  wire logic                        aluCarryUpd,
    input  wire logic                        aluZero,
    input  wire logic                        aluDigitRaw,
    input  wire logic                        aluCarryRaw,
    input  wire logic                        aluSubtract,
    // reset-cause events from watchdog and sleep logic
    input  wire logic                        watchdogExpiry,
    input  wire logic                        watchdogClearOp,
    input  wire logic                        sleepEntryOp,
    // program counter upper byte transfer
    input  wire logic                        pcUpperLoad,
    output logic      [4:0]                  pcUpper,
    output logic      [4:0]                  pcUpperHold,
    // status bits to the datapath
    output logic      [7:0]                  statusOut,
    output logic                             watchdogExpiryFlag,
    output logic                             sleepEntryFlag,
    output logic                             nibbleRippleFlag,
    output logic                             zeroFlag,
    output logic                             carryFlag,
    // bank address forming
    input  wire logic [6:0]                  directOffset,
    input  wire logic [7:0]                  pointerValue,
    output logic      [8:0]                  directAddr,
    output logic      [8:0]                  indirectAddr
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // low seven bits repeat in every bank, so the mirrors fall out
    function automatic logic isStatus(input logic [8:0] idx);
        isStatus = (idx[6:0] == csfr_pkg::STATUS_LOW);
    endfunction

    function automatic logic isPcHold(input logic [8:0] idx);
        isPcHold = (idx[6:0] == csfr_pkg::PCHOLD_LOW);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  statusQ;
    logic [7:0]  statusD;
    logic [4:0]  pcHoldQ;
    logic [4:0]  pcUpperQ;
    logic [31:0] rdataQ;
    logic [8:0]  wordIdx;
    logic        wordAligned;
    logic        setupPhase;
    logic        accessWr;
    logic        statusWr;
    logic        pcHoldWr;
    logic        carryNext;
    logic        digitNext;
    logic        flagUpd;

    // ------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------
    // zero wait states; unmapped words answer zero, never an error
    assign pready      = 1'b1;
    assign pslverr     = 1'b0;
    assign wordIdx     = paddr[csfr_pkg::APB_AW-1:2];
    assign wordAligned = (paddr[1:0] == 2'b00);
    assign setupPhase  = psel && !penable;
    assign accessWr    = psel && penable && pwrite && pstrb[0]
                         && wordAligned;
    // any instruction may target status like other registers
    assign statusWr    = accessWr && isStatus(wordIdx);
    assign pcHoldWr    = accessWr && isPcHold(wordIdx);

    // ------------------------------------------------------------
    // borrow polarity
    // ------------------------------------------------------------
    // alu raw bit is carry on add, borrow on subtract
    assign carryNext = aluSubtract ? !aluCarryRaw : aluCarryRaw;
    assign digitNext = aluSubtract ? !aluDigitRaw : aluDigitRaw;
    // any flag update by the instruction blocks all three flag writes
    assign flagUpd   = aluZeroUpd || aluDigitUpd || aluCarryUpd;

    // ------------------------------------------------------------
    // status next value: write first, alu flags override
    // ------------------------------------------------------------
    // a clear targeting status writes zero and the alu reports zero
    // set; the flag update blocks the carry and digit-carry writes,
    // so the result is 000u u1uu without a special case
    always_comb begin
        statusD = statusQ;
        if (statusWr) begin
            statusD[csfr_pkg::BIT_IBANK] = pwdata[csfr_pkg::BIT_IBANK];
            statusD[csfr_pkg::BIT_RP1] = pwdata[csfr_pkg::BIT_RP1];
            statusD[csfr_pkg::BIT_RP0] = pwdata[csfr_pkg::BIT_RP0];
            if (!flagUpd) begin
                statusD[csfr_pkg::BIT_Z]   = pwdata[csfr_pkg::BIT_Z];
                statusD[csfr_pkg::BIT_NIB] = pwdata[csfr_pkg::BIT_NIB];
                statusD[csfr_pkg::BIT_C]   = pwdata[csfr_pkg::BIT_C];
            end
        end
        if (aluZeroUpd) begin
            statusD[csfr_pkg::BIT_Z] = aluZero;
        end
        if (aluDigitUpd) begin
            statusD[csfr_pkg::BIT_NIB] = digitNext;
        end
        if (aluCarryUpd) begin
            statusD[csfr_pkg::BIT_C] = carryNext;
        end
        // reset-cause flags: writes never reach them; expiry wins over
        // a clear in the same cycle so a timeout is never lost
        if (watchdogClearOp) begin
            statusD[csfr_pkg::BIT_WDOG]  = 1'b1;
            statusD[csfr_pkg::BIT_SLEEP] = 1'b1;
        end else if (sleepEntryOp) begin
            statusD[csfr_pkg::BIT_WDOG]  = 1'b1;
            statusD[csfr_pkg::BIT_SLEEP] = 1'b0;
        end
        if (watchdogExpiry) begin
            statusD[csfr_pkg::BIT_WDOG] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status byte flops
    // ------------------------------------------------------------
    // one process for the whole byte keeps a single driver per bit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            statusQ <= csfr_pkg::STATUS_RST;
        end else begin
            statusQ <= statusD;
        end
    end

    // ------------------------------------------------------------
    // pc upper hold and the counter byte it feeds
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pcHoldQ <= csfr_pkg::PCHOLD_RST;
        end else if (pcHoldWr) begin
            pcHoldQ <= pwdata[csfr_pkg::PCHOLD_W-1:0];
        end
    end

    // the upper byte has no address; only the transfer loads it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pcUpperQ <= csfr_pkg::PCUPPER_RST;
        end else if (pcUpperLoad) begin
            pcUpperQ <= pcHoldQ;
        end
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    // everything not decoded, 19Fh among it, reads as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdataQ <= 32'h0000_0000;
        end else if (setupPhase) begin
            rdataQ <= 32'h0000_0000;
            if (!pwrite && wordAligned) begin
                if (isStatus(wordIdx)) begin
                    rdataQ[7:0] <= statusQ;
                end else if (isPcHold(wordIdx)) begin
                    rdataQ[4:0] <= pcHoldQ;
                end
            end
        end
    end

    assign prdata = rdataQ;

    // ------------------------------------------------------------
    // outputs to the datapath
    // ------------------------------------------------------------
    assign statusOut          = statusQ;
    assign watchdogExpiryFlag = statusQ[csfr_pkg::BIT_WDOG];
    assign sleepEntryFlag     = statusQ[csfr_pkg::BIT_SLEEP];
    assign nibbleRippleFlag   = statusQ[csfr_pkg::BIT_NIB];
    assign zeroFlag           = statusQ[csfr_pkg::BIT_Z];
    assign carryFlag          = statusQ[csfr_pkg::BIT_C];
    assign pcUpper            = pcUpperQ;
    assign pcUpperHold        = pcHoldQ;

    // ------------------------------------------------------------
    // bank address former
    // ------------------------------------------------------------
    csfr_bank_addr u_bank_addr (
        .bankSel         (statusQ[csfr_pkg::BIT_RP1:csfr_pkg::BIT_RP0]),
        .indirectBankBit (statusQ[csfr_pkg::BIT_IBANK]),
        .directOffset    (directOffset),
        .pointerValue    (pointerValue),
        .directAddr      (directAddr),
        .indirectAddr    (indirectAddr)
    );

endmodule

// *** verif/csfr_alu_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// alu flag source of the core datapath
// ----------------------------------------
module csfr_alu_model (
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    input  wire logic       doSub,
    output logic            zeroRes,
    output logic            digitRaw,
    output logic            carryRaw
);
    logic [8:0] res;
    // subtraction reports true borrows; the device flips them
    always_comb begin
        res = doSub ? {1'b0, opA} - {1'b0, opB} : {1'b0, opA} + {1'b0, opB};
        zeroRes = res[7:0] == 8'h00;
        digitRaw = doSub ? opA[3:0] < opB[3:0]
            : ({1'b0, opA[3:0]} + {1'b0, opB[3:0]}) > 5'h0f;
        carryRaw = res[8];
    end
endmodule

// *** verif/csfr_status_reg_assertions.sv ***
`timescale 1ns/1ps
module csfr_status_reg_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [10:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        aluZeroUpd,
    input wire logic        aluDigitUpd,
    input wire logic        aluCarryUpd,
    input wire logic        aluZero,
    input wire logic        aluCarryRaw,
    input wire logic        aluSubtract,
    input wire logic        watchdogExpiry,
    input wire logic        watchdogClearOp,
    input wire logic        sleepEntryOp,
    input wire logic        pcUpperLoad,
    input wire logic [4:0]  pcUpper,
    input wire logic [4:0]  pcUpperHold,
    input wire logic [7:0]  statusOut,
    input wire logic        zeroFlag,
    input wire logic        carryFlag,
    input wire logic [6:0]  directOffset,
    input wire logic [7:0]  pointerValue,
    input wire logic [8:0]  directAddr,
    input wire logic [8:0]  indirectAddr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic wrSt;
    logic wrAny;
    // status write in any bank, aligned, low byte enabled
    assign wrAny = psel && penable && pwrite;
    assign wrSt = wrAny && pstrb[0] && paddr[1:0] == 2'b00
        && paddr[8:2] == 7'h03;
    chk_status_write: assert property (wrSt
        |=> statusOut[7:5] == $past(pwdata[7:5]))
        else $error("status write lost");
    chk_alu_zero: assert property (aluZeroUpd
        |=> zeroFlag == $past(aluZero))
        else $error("zero flag not from alu");
    chk_flag_keep: assert property (wrSt && aluZeroUpd
        && !aluDigitUpd && !aluCarryUpd
        |=> statusOut[1:0] == $past(statusOut[1:0]))
        else $error("write reached alu flags");
    chk_borrow_pol: assert property (aluCarryUpd
        |=> carryFlag == ($past(aluSubtract) ^ $past(aluCarryRaw)))
        else $error("carry polarity wrong");
    chk_cause_ro: assert property (wrAny && !watchdogExpiry
        && !watchdogClearOp && !sleepEntryOp |=> $stable(statusOut[4:3]))
        else $error("reset cause bits written");
    chk_pc_load: assert property (pcUpperLoad
        |=> pcUpper == $past(pcUpperHold))
        else $error("pc upper not loaded");
    chk_unimpl_zero: assert property (psel && !penable
        && paddr[10:2] == 9'h19f |=> prdata == 32'h0)
        else $error("unimplemented read not zero");
    chk_indirect_bank: assert property (
        indirectAddr == {statusOut[7], pointerValue})
        else $error("indirect address wrong");
    chk_direct_bank: assert property (
        directAddr == {statusOut[6:5], directOffset})
        else $error("direct address wrong");
endmodule
bind csfr_status_reg csfr_status_reg_chk chk_inst (.*);

// *** verif/cpu_status_flags_register_tb.sv ***
`timescale 1ns/1ps
module cpu_status_flags_register_tb;
    logic        sys_clk = 1'b0, sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [10:0] paddr = 11'h000;
    logic [31:0] pwdata = 32'h0, prdata, d, r;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, aluZero, aluDigitRaw, aluCarryRaw;
    logic        aluZeroUpd = 1'b0, aluFlagUpd = 1'b0, aluSubtract = 1'b0;
    logic        aluDigitUpd, aluCarryUpd, pcUpperLoad = 1'b0;
    logic        watchdogExpiry = 1'b0, watchdogClearOp = 1'b0;
    logic        sleepEntryOp = 1'b0, watchdogExpiryFlag, sleepEntryFlag;
    logic        nibbleRippleFlag, zeroFlag, carryFlag;
    logic [4:0]  pcUpper, pcUpperHold;
    logic [7:0]  statusOut, opA = 8'h00, opB = 8'h00, pointerValue = 8'h00;
    logic [6:0]  directOffset = 7'h00;
    logic [8:0]  directAddr, indirectAddr;
    int          nFail = 0, samplesChecked = 0, i, ma, mb, res, sm;
    int          seed = 32'hfa1330a6;
    assign aluDigitUpd = aluFlagUpd;
    assign aluCarryUpd = aluFlagUpd;
    csfr_status_reg csfr_status_reg_inst (.*);
    csfr_alu_model csfr_alu_model_inst (.opA(opA), .opB(opB),
        .doSub(aluSubtract), .zeroRes(aluZero), .digitRaw(aluDigitRaw),
        .carryRaw(aluCarryRaw));
    always #10 sys_clk = ~sys_clk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // apb transfer; clr raises the zero update during the access
    task automatic apb(input logic w, input logic [10:0] a,
                       input logic [31:0] wd, input logic clr);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        aluZeroUpd <= clr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            nFail++;
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        aluZeroUpd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        sm = 8'h18;
        check("status", statusOut, sm);
        // reset-cause events: clear op, sleep, expiry
        for (i = 0; i < 3; i++) begin
            watchdogClearOp <= i == 0;
            sleepEntryOp <= i == 1;
            watchdogExpiry <= i == 2;
            @(posedge sys_clk);
            watchdogClearOp <= 1'b0;
            sleepEntryOp <= 1'b0;
            watchdogExpiry <= 1'b0;
            @(posedge sys_clk);
            sm = i == 0 ? sm | 8'h18 : i == 1 ? sm & 8'he7 | 8'h10 : sm & 8'hef;
            check("cause", statusOut, sm);
        end
        // moves into every mirror, read back through the next one
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            pointerValue <= d[15:8];
            directOffset <= d[22:16];
            apb(1'b1, 11'(12 + i % 4 * 512), d, 1'b0);
            sm = d[7:0] & 8'he7 | sm & 8'h18;
            apb(1'b0, 11'(12 + (i + 1) % 4 * 512), 32'h0, 1'b0);
            check("status", r, sm);
            check("indirect", indirectAddr, sm / 128 * 256 + d[15:8]);
            check("direct", directAddr, sm / 32 % 4 * 128 + d[22:16]);
        end
        // clear on status: only the zero update is raised
        opA <= 8'h00;
        opB <= 8'h00;
        @(posedge sys_clk);
        apb(1'b1, 11'h20c, 32'h0, 1'b1);
        sm = sm & 8'h1b | 8'h04;
        check("clear", statusOut, sm);
        // alu results, add and subtract alternating
        for (i = 0; i < 16; i++) begin
            d = $random(seed);
            ma = d[7:0];
            mb = d[15:8];
            opA <= d[7:0];
            opB <= d[15:8];
            aluSubtract <= 1'(i % 2);
            aluZeroUpd <= 1'b1;
            aluFlagUpd <= 1'b1;
            @(posedge sys_clk);
            aluZeroUpd <= 1'b0;
            aluFlagUpd <= 1'b0;
            @(posedge sys_clk);
            res = i % 2 ? ma - mb : ma + mb;
            sm = sm & 8'hf8 | (res % 256 == 0) * 4 | (i % 2 ?
                (ma % 16 >= mb % 16) * 2 + (ma >= mb)
                : (ma % 16 + mb % 16 > 15) * 2 + (res > 255));
            check("flags", statusOut, sm);
            check("bits", {watchdogExpiryFlag, sleepEntryFlag, zeroFlag,
                nibbleRippleFlag, carryFlag}, sm % 32);
        end
        // pc upper hold and transfer
        d = $random(seed);
        apb(1'b1, 11'h028, d, 1'b0);
        apb(1'b0, 11'h628, 32'h0, 1'b0);
        check("hold", r, d & 32'h1f);
        pcUpperLoad <= 1'b1;
        @(posedge sys_clk);
        pcUpperLoad <= 1'b0;
        @(posedge sys_clk);
        check("pcUpper", pcUpper, d & 32'h1f);
        check("holdOut", pcUpperHold, d & 32'h1f);
        // unimplemented location: write ignored, reads zero
        apb(1'b1, 11'h67c, 32'hff, 1'b0);
        check("unimplWr", statusOut, sm);
        check("holdKeep", pcUpperHold, d & 32'h1f);
        apb(1'b0, 11'h67c, 32'h0, 1'b0);
        check("unimpl", r, 32'h0);
        check("resp", {pready, pslverr}, 32'h2);
        wrap_up;
    end
    // hang guard: well beyond the roughly 110 cycles the run needs
    initial begin
        repeat (3000) @(posedge sys_clk);
        nFail++;
        wrap_up;
    end
endmodule
